// >>> pei_pkg.sv
// Constants, register map and state types of the PHY event interrupt unit.
// Assumes a single 50 MHz clock and an AXI4-Lite register bus with 32-bit data.
package pei_pkg;

  // Bus widths
  localparam int          AXI_AW   = 12;
  localparam int          AXI_DW   = 32;

  // Register indices as printed; byte address is four times the index
  localparam logic [9:0]  IDX_CTRL = 10'h011;
  localparam logic [9:0]  IDX_STAT = 10'h012;
  localparam logic [9:0]  IDX_FCT  = 10'h014;
  localparam logic [9:0]  IDX_RXE  = 10'h015;
  localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [11:0] ADDR_FCT  = {IDX_FCT, 2'b00};
  localparam logic [11:0] ADDR_RXE  = {IDX_RXE, 2'b00};

  // Control register fields (bits 3:0 implemented, rest read zero)
  localparam int          CTRL_W       = 4;
  localparam int          CTRL_OE_BIT  = 0;
  localparam int          CTRL_GATE_BIT = 1;
  localparam int          CTRL_FORCE_BIT = 2;
  localparam int          CTRL_POL_BIT = 3;
  localparam logic [3:0]  CTRL_RESET   = 4'h8;

  // Event order, shared by enables (5:0) and flags (13:8)
  localparam int          EVT_N        = 6;
  localparam int          EVT_LINK     = 5;
  localparam int          EVT_SPEED    = 4;
  localparam int          EVT_DUPLEX   = 3;
  localparam int          EVT_AN       = 2;
  localparam int          EVT_FC       = 1;
  localparam int          EVT_RE       = 0;
  localparam logic [5:0]  EVT_RESET    = 6'h00;

  // Tally widths and half-full thresholds
  localparam int          FC_W         = 8;
  localparam logic [7:0]  FC_HALF      = 8'h7F;
  localparam int          RXE_W        = 16;
  localparam logic [15:0] RXE_HALF     = 16'h7FFF;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    PEI_WR_COLLECT = 2'b01,
    PEI_WR_RESP    = 2'b10
  } pei_wr_e;

  typedef enum logic [1:0] {
    PEI_RD_IDLE = 2'b01,
    PEI_RD_RESP = 2'b10
  } pei_rd_e;

endpackage : pei_pkg

// >>> pei_cnt_if.sv
// Interface between the unit and one saturating error tally.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface pei_cnt_if #(parameter int W = 8);
  logic         inc;
  logic         clr;
  logic [W-1:0] count;
  logic         half;

  modport tally (input inc, input clr, output count, output half);
  modport user  (output inc, output clr, input count, input half);
endinterface : pei_cnt_if

// >>> pei_sat_counter.sv
// Saturating tally, cleared on read, with a pulse when it passes half full.
// Assumes increment and clear come from logic on the same clock.
`timescale 1ns/1ns
module pei_sat_counter #(
  parameter int         W    = 8,
  parameter logic [W-1:0] HALF = '0
) (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  pei_cnt_if.tally      cnt
);

  localparam logic [W-1:0] TOP = '1;

  // Clear wins over count but the coinciding increment is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt.count <= '0;
    end else if (cnt.clr) begin
      cnt.count <= cnt.inc ? W'(1) : '0;
    end else if (cnt.inc && cnt.count != TOP) begin
      cnt.count <= cnt.count + W'(1);
    end
  end

  // Passing the midpoint is one event, not a level
  assign cnt.half = cnt.inc && !cnt.clr && (cnt.count == HALF);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cnt_saturate: assert property ((cnt.count == TOP && !cnt.clr) |=> cnt.count == TOP)
    else $error("tally left its saturated value");
  a_cnt_clear: assert property ((cnt.clr && !cnt.inc) |=> cnt.count == '0)
    else $error("tally not cleared by read");
  a_half_pulse: assert property (cnt.half |=> (cnt.count == HALF + W'(1)) && !cnt.half)
    else $error("half-full event without passing the midpoint");

endmodule : pei_sat_counter

// >>> pei_top.sv
// PHY event interrupt unit: control and event status registers, error tallies,
// and the shared interrupt / power-down pin.
// Assumes PHY status levels and error pulses on the bus clock; pin input is async.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns

// Summary of operation
// - With polarity select one, pin idles high and goes low on interrupt.
// - With polarity select zero, pin idles low and goes high on interrupt.
// - Force bit raises an interrupt independent of events; clears to zero at reset.
// - The forced interrupt lasts as long as the force bit stays set.
// - Global gate must be set; then per-event enables pick interrupting events.
// - Pin function bit: one makes shared pin interrupt output, zero power-down input.
// - Interrupts reach the pin only while it is configured as output.
// - A status bit is set if its event happened since the last read.
// - An event interrupts only when its own enable bit is set.
// - Gate and pin function both needed for event interrupts; otherwise no signalling.
// - Status bits latch events even when enables or gate are off.
// - Bit 13 flags link change; read-only, reset zero, cleared by reading.
// - Bit 12 flags speed change and holds until the register is read.
// - Bit 11 flags duplex change and holds until the register is read.
// - Bit 10 flags auto-negotiation complete and holds until read.
// - Bit 9 flags false-carrier tally passing half full, held until read.
// - Bit 8 flags receive-error tally passing half full, held until read.
// - Enable bits 5..0 cover link, speed, duplex, negotiation, false carrier, rx error.
// - Status bits 15:14 and 7:6 read zero and ignore writes.
// - False-carrier tally is 8 bits, saturates at FFh, clears on read.
// - Receive-error tally is 16 bits, saturates at FFFFh, clears on read.
module pei_top
  import pei_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // AXI4-Lite slave
  input  wire logic [AXI_AW-1:0] axi_awaddr_i,
  input  wire logic              axi_awvalid_i,
  output logic                   axi_awready_o,
  input  wire logic [AXI_DW-1:0] axi_wdata_i,
  input  wire logic [3:0]        axi_wstrb_i,
  input  wire logic              axi_wvalid_i,
  output logic                   axi_wready_o,
  output logic [1:0]             axi_bresp_o,
  output logic                   axi_bvalid_o,
  input  wire logic              axi_bready_i,
  input  wire logic [AXI_AW-1:0] axi_araddr_i,
  input  wire logic              axi_arvalid_i,
  output logic                   axi_arready_o,
  output logic [AXI_DW-1:0]      axi_rdata_o,
  output logic [1:0]             axi_rresp_o,
  output logic                   axi_rvalid_o,
  input  wire logic              axi_rready_i,
  // PHY status levels and error pulses
  input  wire logic              link_up_i,
  input  wire logic              speed_100_i,
  input  wire logic              full_duplex_i,
  input  wire logic              autoneg_done_i,
  input  wire logic              false_carrier_i,
  input  wire logic              rx_symbol_error_i,
  // Shared interrupt / power-down pin
  input  wire logic              irq_or_powerdown_pin_i,
  output logic                   irq_or_powerdown_pin_o,
  output logic                   irq_or_powerdown_pin_oe_o,
  output logic                   powerdown_o
);

  pei_wr_e            wr_state;
  pei_rd_e            rd_state;
  logic               aw_held;
  logic               w_held;
  logic [AXI_AW-1:0]  awaddr_q;
  logic [AXI_DW-1:0]  wdata_q;
  logic [3:0]         wstrb_q;
  logic [AXI_AW-1:0]  wr_addr;
  logic [AXI_DW-1:0]  wr_data;
  logic [3:0]         wr_strb;
  logic               aw_now;
  logic               w_now;
  logic               wr_fire;
  logic               wr_lane0;
  logic               rd_fire;
  logic [AXI_DW-1:0]  rd_word;
  logic [1:0]         rd_resp;
  logic [1:0]         wr_resp;
  logic               stat_rd;

  logic [CTRL_W-1:0]  phy_interrupt_control;
  logic [EVT_N-1:0]   event_enable;
  logic [EVT_N-1:0]   event_flag;
  logic [EVT_N-1:0]   event_now;
  logic [15:0]        event_status_enable_one;
  logic               primed;
  logic               link_q;
  logic               speed_q;
  logic               duplex_q;
  logic               autoneg_q;
  logic               irq_active;
  logic               pin_meta;
  logic               pin_sync;

  logic irq_or_powerdown_pin;
  logic irq_level_select;
  logic irq_force;
  logic irq_gate;

  pei_cnt_if #(.W(FC_W))  false_carrier_tally ();
  pei_cnt_if #(.W(RXE_W)) rx_symbol_error_tally ();

  assign irq_or_powerdown_pin = phy_interrupt_control[CTRL_OE_BIT];
  assign irq_level_select     = phy_interrupt_control[CTRL_POL_BIT];
  assign irq_force            = phy_interrupt_control[CTRL_FORCE_BIT];
  assign irq_gate             = phy_interrupt_control[CTRL_GATE_BIT];

  // Write channel: address and data may arrive in either order
  assign axi_awready_o = (wr_state == PEI_WR_COLLECT) && !aw_held;
  assign axi_wready_o  = (wr_state == PEI_WR_COLLECT) && !w_held;
  assign axi_bvalid_o  = (wr_state == PEI_WR_RESP);
  assign aw_now   = axi_awvalid_i && axi_awready_o;
  assign w_now    = axi_wvalid_i && axi_wready_o;
  assign wr_fire  = (wr_state == PEI_WR_COLLECT) && (aw_held || aw_now) && (w_held || w_now);
  assign wr_addr  = aw_held ? awaddr_q : axi_awaddr_i;
  assign wr_data  = w_held ? wdata_q : axi_wdata_i;
  assign wr_strb  = w_held ? wstrb_q : axi_wstrb_i;
  assign wr_lane0 = wr_fire && wr_strb[0];

  // Write responses: registers that exist answer OKAY, read-only ones ignore data
  always_comb begin
    if (wr_addr == ADDR_CTRL || wr_addr == ADDR_STAT) begin
      wr_resp = RESP_OKAY;
    end else if (wr_addr == ADDR_FCT || wr_addr == ADDR_RXE) begin
      wr_resp = RESP_OKAY;
    end else begin
      wr_resp = RESP_SLVERR;
    end
  end

  // Write handshake state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_state    <= PEI_WR_COLLECT;
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      awaddr_q    <= '0;
      wdata_q     <= '0;
      wstrb_q     <= '0;
      axi_bresp_o <= RESP_OKAY;
    end else begin
      case (wr_state)
        PEI_WR_COLLECT: begin
          if (wr_fire) begin
            wr_state    <= PEI_WR_RESP;
            aw_held     <= 1'b0;
            w_held      <= 1'b0;
            axi_bresp_o <= wr_resp;
          end else begin
            if (aw_now) begin
              aw_held  <= 1'b1;
              awaddr_q <= axi_awaddr_i;
            end
            if (w_now) begin
              w_held  <= 1'b1;
              wdata_q <= axi_wdata_i;
              wstrb_q <= axi_wstrb_i;
            end
          end
        end
        PEI_WR_RESP: begin
          if (axi_bready_i) begin
            wr_state <= PEI_WR_COLLECT;
          end
        end
        default: begin
          wr_state <= PEI_WR_COLLECT;
        end
      endcase
    end
  end

  // Read channel: one read at a time, answer one cycle after the address
  assign axi_arready_o = (rd_state == PEI_RD_IDLE);
  assign axi_rvalid_o  = (rd_state == PEI_RD_RESP);
  assign rd_fire       = axi_arvalid_i && axi_arready_o;
  assign stat_rd       = rd_fire && (axi_araddr_i == ADDR_STAT);

  // Reserved positions are tied low in the assembled word
  assign event_status_enable_one = {2'b00, event_flag, 2'b00, event_enable};

  // Read data select
  always_comb begin
    rd_word = '0;
    rd_resp = RESP_OKAY;
    if (axi_araddr_i == ADDR_CTRL) begin
      rd_word = AXI_DW'(phy_interrupt_control);
    end else if (axi_araddr_i == ADDR_STAT) begin
      rd_word = AXI_DW'(event_status_enable_one);
    end else if (axi_araddr_i == ADDR_FCT) begin
      rd_word = AXI_DW'(false_carrier_tally.count);
    end else if (axi_araddr_i == ADDR_RXE) begin
      rd_word = AXI_DW'(rx_symbol_error_tally.count);
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  // Read handshake state; data captured at the address edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_state    <= PEI_RD_IDLE;
      axi_rdata_o <= '0;
      axi_rresp_o <= RESP_OKAY;
    end else begin
      case (rd_state)
        PEI_RD_IDLE: begin
          if (rd_fire) begin
            rd_state    <= PEI_RD_RESP;
            axi_rdata_o <= rd_word;
            axi_rresp_o <= rd_resp;
          end
        end
        PEI_RD_RESP: begin
          if (axi_rready_i) begin
            rd_state <= PEI_RD_IDLE;
          end
        end
        default: begin
          rd_state <= PEI_RD_IDLE;
        end
      endcase
    end
  end

  // Control register; only lane 0 holds implemented bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phy_interrupt_control <= CTRL_RESET;
    end else if (wr_lane0 && wr_addr == ADDR_CTRL) begin
      phy_interrupt_control <= wr_data[CTRL_W-1:0];
    end
  end

  // Event enables; flag and reserved positions ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_enable <= EVT_RESET;
    end else if (wr_lane0 && wr_addr == ADDR_STAT) begin
      event_enable <= wr_data[EVT_N-1:0];
    end
  end

  // Previous status levels; primed keeps reset from looking like a change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primed    <= 1'b0;
      link_q    <= 1'b0;
      speed_q   <= 1'b0;
      duplex_q  <= 1'b0;
      autoneg_q <= 1'b0;
    end else begin
      primed    <= 1'b1;
      link_q    <= link_up_i;
      speed_q   <= speed_100_i;
      duplex_q  <= full_duplex_i;
      autoneg_q <= autoneg_done_i;
    end
  end

  // Event detection, in enable-bit order
  always_comb begin
    event_now             = '0;
    event_now[EVT_LINK]   = primed && (link_up_i != link_q);
    event_now[EVT_SPEED]  = primed && (speed_100_i != speed_q);
    event_now[EVT_DUPLEX] = primed && (full_duplex_i != duplex_q);
    event_now[EVT_AN]     = primed && autoneg_done_i && !autoneg_q;
    event_now[EVT_FC]     = false_carrier_tally.half;
    event_now[EVT_RE]     = rx_symbol_error_tally.half;
  end

  // Sticky flags, set regardless of enables; a set beats the clearing read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_flag <= EVT_RESET;
    end else begin
      event_flag <= (event_flag & ~{EVT_N{stat_rd}}) | event_now;
    end
  end

  // Error tallies, cleared by a read of their own address
  assign false_carrier_tally.inc   = false_carrier_i;
  assign false_carrier_tally.clr   = rd_fire && (axi_araddr_i == ADDR_FCT);
  assign rx_symbol_error_tally.inc = rx_symbol_error_i;
  assign rx_symbol_error_tally.clr = rd_fire && (axi_araddr_i == ADDR_RXE);

  pei_sat_counter #(.W(FC_W), .HALF(FC_HALF)) u_fc_tally (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cnt   (false_carrier_tally)
  );

  pei_sat_counter #(.W(RXE_W), .HALF(RXE_HALF)) u_rxe_tally (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cnt   (rx_symbol_error_tally)
  );

  // Interrupt condition: forced, or gated and enabled pending flags
  assign irq_active = irq_force || (irq_gate && |(event_flag & event_enable));

  // Pin drive registered so it never glitches on a decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_or_powerdown_pin_o    <= CTRL_RESET[CTRL_POL_BIT];
      irq_or_powerdown_pin_oe_o <= 1'b0;
    end else begin
      irq_or_powerdown_pin_o    <= irq_level_select ^ irq_active;
      irq_or_powerdown_pin_oe_o <= irq_or_powerdown_pin;
    end
  end

  // Pin as power-down input: synchronise, then active low request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta    <= 1'b1;
      pin_sync    <= 1'b1;
      powerdown_o <= 1'b0;
    end else begin
      pin_meta    <= irq_or_powerdown_pin_i;
      pin_sync    <= pin_meta;
      powerdown_o <= !irq_or_powerdown_pin && !pin_sync;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctrl_write;
    wr_lane0 && wr_addr == ADDR_CTRL;
  endsequence

  sequence s_stat_clear;
    stat_rd && event_now == '0;
  endsequence

  a_pol_idle_high: assert property ((irq_level_select && !irq_active) |=> irq_or_powerdown_pin_o)
    else $error("pin not high while idle under default polarity");
  a_pol_active_high: assert property ((!irq_level_select && irq_active) |=> irq_or_powerdown_pin_o)
    else $error("pin not high while active under inverted polarity");
  a_force_write: assert property (s_ctrl_write |=> irq_force == $past(wr_data[CTRL_FORCE_BIT]))
    else $error("force bit did not take written value");
  a_force_holds: assert property (irq_force |=> irq_or_powerdown_pin_o ^ $past(irq_level_select))
    else $error("forced interrupt not shown on the pin");
  a_gate_blocks: assert property ((!irq_gate && !irq_force) |-> !irq_active)
    else $error("event interrupt without global gate");
  a_pin_released: assert property (!irq_or_powerdown_pin |=> !irq_or_powerdown_pin_oe_o)
    else $error("pin driven while configured as input");
  a_flag_sticky: assert property (!stat_rd |=> (event_flag & $past(event_flag)) == $past(event_flag))
    else $error("status flag lost without a read");
  a_enable_masks: assert property ((!irq_force && (event_flag & event_enable) == '0) |-> !irq_active)
    else $error("interrupt from a disabled event");
  a_event_latched: assert property ((event_now != '0) |=> (event_flag & $past(event_now)) == $past(event_now))
    else $error("event not latched into status");
  a_read_clears: assert property (s_stat_clear |=> event_flag == '0)
    else $error("status not cleared by read");
  a_reserved_zero: assert property ((rd_fire && axi_araddr_i == ADDR_STAT) |=> (axi_rdata_o[15:14] == 2'b00) && (axi_rdata_o[7:6] == 2'b00))
    else $error("reserved status bits read nonzero");

endmodule : pei_top

// >>> pei_host_model.sv
// Host side of the shared interrupt / power-down line.
// Assumes the line is pulled up at the host and the device drives it only while its enable is high.
`timescale 1ns/1ns
module pei_host_model (
  input  wire logic pin_o_i,
  input  wire logic pin_oe_i,
  input  wire logic pd_request_i,
  output logic      pin_level_o
);
  // Resolve the wire; host only pulls low when the device has released it
  always_comb begin
    if (pin_oe_i) begin
      pin_level_o = pin_o_i;
    end else if (pd_request_i) begin
      pin_level_o = 1'b0;
    end else begin
      pin_level_o = 1'b1; // Pull-up, never a stale value
    end
  end
endmodule : pei_host_model

// >>> testbench.sv
// Self-checking bench for the PHY event interrupt unit.
// Assumes pei_top, pei_pkg and the host line model; one 50 MHz clock.
`timescale 1ns/1ns
module testbench;
  import pei_pkg::*;
  localparam int TIMEOUT = 80000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [11:0] aw_addr = '0, ar_addr = '0;
  logic [31:0] w_data = '0;
  logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic [3:0]  lvl = 4'h0;
  logic [1:0]  errp = 2'h0;
  logic        pd_req = 1'b0;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, pin_o, pin_oe, pd_o, pin_lvl;
  logic [1:0]  b_resp, r_resp;
  logic [31:0] r_data;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;

  pei_top dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .axi_awaddr_i(aw_addr), .axi_awvalid_i(aw_valid), .axi_awready_o(aw_ready),
    .axi_wdata_i(w_data), .axi_wstrb_i(4'hF), .axi_wvalid_i(w_valid), .axi_wready_o(w_ready),
    .axi_bresp_o(b_resp), .axi_bvalid_o(b_valid), .axi_bready_i(b_ready),
    .axi_araddr_i(ar_addr), .axi_arvalid_i(ar_valid), .axi_arready_o(ar_ready),
    .axi_rdata_o(r_data), .axi_rresp_o(r_resp), .axi_rvalid_o(r_valid), .axi_rready_i(r_ready),
    .link_up_i(lvl[3]), .speed_100_i(lvl[2]), .full_duplex_i(lvl[1]), .autoneg_done_i(lvl[0]),
    .false_carrier_i(errp[1]), .rx_symbol_error_i(errp[0]),
    .irq_or_powerdown_pin_i(pin_lvl), .irq_or_powerdown_pin_o(pin_o),
    .irq_or_powerdown_pin_oe_o(pin_oe), .powerdown_o(pd_o));

  pei_host_model host_u (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .pd_request_i(pd_req),
    .pin_level_o(pin_lvl));

  // Clock
  always #10 clk_i = ~clk_i;

  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic pin_is(input logic e);
    chk("pin", {31'h0, e}, {31'h0, pin_lvl});
  endtask : pin_is

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // Write: address and data offered together, each released when taken
  task automatic wrx(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk_i);
    aw_addr <= a; aw_valid <= 1'b1; w_data <= {16'h0000, d}; w_valid <= 1'b1; b_ready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (aw_ok && w_ok && b_valid) begin
        chk("bresp", {30'h0, er}, {30'h0, b_resp});
        b_ready <= 1'b0;
        break;
      end
      if (!aw_ok && aw_ready) begin aw_ok = 1; aw_valid <= 1'b0; end
      if (!w_ok && w_ready) begin w_ok = 1; w_valid <= 1'b0; end
    end
  endtask : wrx

  // Read and compare data and response
  task automatic rdx(input string what, input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er = RESP_OKAY);
    bit ar_ok;
    ar_ok = 0;
    @(posedge clk_i);
    ar_addr <= a; ar_valid <= 1'b1; r_ready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (ar_ok && r_valid) begin
        chk(what, e, r_data);
        chk("rresp", {30'h0, er}, {30'h0, r_resp});
        r_ready <= 1'b0;
        break;
      end
      if (!ar_ok && ar_ready) begin ar_ok = 1; ar_valid <= 1'b0; end
    end
  endtask : rdx

  // Toggle one status level, bit 3 link down to bit 0 negotiation
  task automatic flip(input int i);
    @(posedge clk_i);
    lvl <= lvl ^ (4'h8 >> i);
    cyc(3);
  endtask : flip

  // Hold an error line high for n cycles, n counts
  task automatic pulse(input bit fc, input int n);
    @(posedge clk_i);
    errp <= fc ? 2'h2 : 2'h1;
    cyc(n);
    errp <= 2'h0;
  endtask : pulse

  task automatic t_reset();
    rdx("ctrl", ADDR_CTRL, 32'h00000008);
    rdx("stat", ADDR_STAT, 32'h00000000);
    rdx("fct", ADDR_FCT, 32'h00000000);
    rdx("rxe", ADDR_RXE, 32'h00000000);
    rdx("unmapped", 12'h000, 32'h00000000, RESP_SLVERR);
    wrx(12'h0FC, 16'hFFFF, RESP_SLVERR);
    chk("pin_oe", 32'h0, {31'h0, pin_oe});
  endtask : t_reset

  task automatic t_reserved();
    wrx(ADDR_STAT, 16'hFFFF, RESP_OKAY);
    rdx("stat", ADDR_STAT, 32'h0000003F);
    wrx(ADDR_STAT, 16'h0000, RESP_OKAY);
  endtask : t_reserved

  // Every level event is latched with all enables off, then cleared by read
  task automatic t_poll();
    for (int i = 0; i < 4; i++) begin
      flip(i);
      rdx("stat", ADDR_STAT, 32'h00002000 >> i);
      rdx("stat", ADDR_STAT, 32'h00000000);
    end
    pin_is(1'b1);
  endtask : t_poll

  task automatic t_irq();
    wrx(ADDR_CTRL, 16'h000B, RESP_OKAY);
    wrx(ADDR_STAT, 16'h0020, RESP_OKAY);
    pin_is(1'b1);
    flip(0);
    pin_is(1'b0);
    cyc(20);
    pin_is(1'b0);
    rdx("stat", ADDR_STAT, 32'h00002020);
    cyc(3);
    pin_is(1'b1);
    wrx(ADDR_CTRL, 16'h0003, RESP_OKAY);
    cyc(3);
    pin_is(1'b0);
    flip(0);
    pin_is(1'b1);
    rdx("stat", ADDR_STAT, 32'h00002020);
    flip(1);
    pin_is(1'b0);
    rdx("stat", ADDR_STAT, 32'h00001020);
    wrx(ADDR_CTRL, 16'h0009, RESP_OKAY);
    flip(0);
    pin_is(1'b1);
    rdx("stat", ADDR_STAT, 32'h00002020);
    wrx(ADDR_CTRL, 16'h000A, RESP_OKAY);
    flip(0);
    chk("pin_oe", 32'h0, {31'h0, pin_oe});
    pin_is(1'b1);
    rdx("stat", ADDR_STAT, 32'h00002020);
  endtask : t_irq

  // Forced interrupt holds while the bit stays set
  task automatic t_force();
    wrx(ADDR_CTRL, 16'h000D, RESP_OKAY);
    cyc(3);
    pin_is(1'b0);
    repeat (5) begin
      cyc(10);
      pin_is(1'b0);
    end
    wrx(ADDR_CTRL, 16'h0009, RESP_OKAY);
    cyc(3);
    pin_is(1'b1);
    rdx("ctrl", ADDR_CTRL, 32'h00000009);
  endtask : t_force

  task automatic t_tally();
    pulse(1'b1, 127);
    rdx("stat", ADDR_STAT, 32'h00000020);
    pulse(1'b1, 1);
    rdx("stat", ADDR_STAT, 32'h00000220);
    rdx("fct", ADDR_FCT, 32'h00000080);
    rdx("fct", ADDR_FCT, 32'h00000000);
    pulse(1'b1, 300);
    rdx("fct", ADDR_FCT, 32'h000000FF);
    pulse(1'b0, 32767);
    rdx("stat", ADDR_STAT, 32'h00000220);
    pulse(1'b0, 1);
    rdx("stat", ADDR_STAT, 32'h00000120);
    pulse(1'b0, 32770);
    rdx("rxe", ADDR_RXE, 32'h0000FFFF);
    rdx("rxe", ADDR_RXE, 32'h00000000);
  endtask : t_tally

  // Shared pin used as power-down input
  task automatic t_pd();
    wrx(ADDR_CTRL, 16'h0008, RESP_OKAY);
    @(posedge clk_i);
    pd_req <= 1'b1;
    cyc(5);
    chk("powerdown", 32'h1, {31'h0, pd_o});
    pd_req <= 1'b0;
    cyc(5);
    chk("powerdown", 32'h0, {31'h0, pd_o});
  endtask : t_pd

  // Main sequence
  initial begin
    cyc(10);
    rst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_reserved();
    t_poll();
    t_irq();
    t_force();
    t_tally();
    t_pd();
    end_of_test();
  end
endmodule : testbench
